/* logic/adcc_top.sv */
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "adcc_defs.svh"
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_strobe,
  input  wire logic       rd_strobe,
  output logic      [7:0] rd_data,
  input  wire logic       stop_mode,
  input  wire logic [9:0] sar_result,
  output logic            irq_req,
  output logic            conv_power_en,
  output logic            sample_hold,
  output logic      [4:0] mux_select
);

  localparam adcc_top_s RESET_ST = '{
    state:    ADCC_ST_IDLE,
    chan:     `ADCC_CHAN_RESET,
    presc:    `ADCC_PRESC_RESET,
    mode:     adcc_mode_e'(`ADCC_MODE_RESET),
    mux_sel:  `ADCC_CHAN_RESET,
    default:  '0
  };

  adcc_top_s  st;
  adcc_top_s  next_st;
  logic       tick;
  logic [7:0] fmt_high;
  logic [7:0] fmt_low;
  logic       wr_sc;
  logic       wr_ck;
  logic       rd_high;
  logic       rd_low;
  logic       rd_res;
  logic       conv_end;
  logic       locked_now;
  adcc_mode_e wr_mode;

  // interlock applies only to the three ten-bit formats
  function automatic logic adcc_interlocked(input adcc_mode_e m);
    return m != ADCC_MODE_TRUNC;
  endfunction

  adcc_prescaler u_presc (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .run     (st.state == ADCC_ST_CONVERT && !wr_sc),
    .code    (st.presc),
    .tick    (tick)
  );

  adcc_formatter u_fmt (
    .result (st.sync2),
    .mode   (st.mode),
    .high   (fmt_high),
    .low    (fmt_low)
  );

  assign wr_sc   = ce && wr_strobe && addr == `ADCC_OFF_STATUS;
  assign wr_ck   = ce && wr_strobe && addr == `ADCC_OFF_CLOCK;
  assign rd_high = ce && rd_strobe && addr == `ADCC_OFF_HIGH;
  assign rd_low  = ce && rd_strobe && addr == `ADCC_OFF_LOW;
  assign rd_res  = rd_high || rd_low;
  assign wr_mode = adcc_mode_e'(wr_data[`ADCC_CK_MODE_MSB:`ADCC_CK_MODE_LSB]);

  // sixteenth converter tick ends the conversion
  assign conv_end = st.state == ADCC_ST_CONVERT && tick
                    && st.tick_cnt == `ADCC_CONV_LAST && !stop_mode && !wr_sc;

  // a high read in the same cycle as the end already counts as locked
  assign locked_now = adcc_interlocked(st.mode) && (st.lock || rd_high);

  always_comb
  begin
    next_st = st;
    if (ce)
    begin
      // sar bits come from the analog side, two stages before use
      next_st.sync1   = sar_result;
      next_st.sync2   = st.sync1;
      next_st.rd_data = 8'h00;

      if (rd_strobe)
      begin
        case (addr)
          // done reads zero while interrupt enabled
          `ADCC_OFF_STATUS: next_st.rd_data = {st.conv_done && !st.irq_en, st.irq_en,
                                               st.cont, st.chan};
          `ADCC_OFF_HIGH:   next_st.rd_data = st.res_high;
          `ADCC_OFF_LOW:    next_st.rd_data = st.res_low;
          `ADCC_OFF_CLOCK:  next_st.rd_data = {st.presc, 1'b0, st.mode, 2'b00};
          default:          next_st.rd_data = 8'h00;
        endcase
      end

      if (rd_res)
        next_st.conv_done = 1'b0;
      // read or status write drops interrupt
      if (rd_res || wr_sc)
        next_st.irq = 1'b0;

      // high read locks, low read releases
      if (rd_high && adcc_interlocked(st.mode))
        next_st.lock = 1'b1;
      if (rd_low)
        next_st.lock = 1'b0;

      if (wr_ck)
      begin
        next_st.presc = wr_data[`ADCC_CK_PRESC_MSB:`ADCC_CK_PRESC_LSB];
        next_st.mode  = wr_mode;
        if (!adcc_interlocked(wr_mode))
          next_st.lock = 1'b0;
      end

      if (wr_sc)
      begin
        // status field layout, done bit write ignored
        next_st.irq_en   = wr_data[`ADCC_SC_IE_BIT];
        next_st.cont     = wr_data[`ADCC_SC_CONT_BIT];
        next_st.chan     = wr_data[`ADCC_SC_CHAN_MSB:`ADCC_SC_CHAN_LSB];
        next_st.tick_cnt = 4'h0;
        if (wr_data[`ADCC_SC_IE_BIT])
          next_st.conv_done = 1'b0;
        if (wr_data[`ADCC_SC_CHAN_MSB:`ADCC_SC_CHAN_LSB] == `ADCC_CHAN_OFF)
          next_st.state = ADCC_ST_IDLE;
        // a status write outside stop mode with a channel code other than all-ones starts a conversion, except in the cycle leaving stop, where pend decides the state
        else
          next_st.state = ADCC_ST_CONVERT;
      end
      else if (conv_end)
      begin
        // results during an open read pair are dropped
        if (!locked_now)
        begin
          next_st.res_high = fmt_high;
          next_st.res_low  = fmt_low;
        end
        // interrupt path runs only outside stop mode, since conv_end is gated by !stop_mode
        // enabled interrupt keeps done flag clear
        if (st.irq_en)
          next_st.irq = 1'b1;
        // set wins over a same-cycle read
        else
          next_st.conv_done = 1'b1;
        next_st.tick_cnt = 4'h0;
        if (!st.cont)
          next_st.state = ADCC_ST_IDLE;
      end
      else if (st.state == ADCC_ST_CONVERT && tick)
        next_st.tick_cnt = st.tick_cnt + 4'h1;

      if (stop_mode)
      begin
        if (st.state != ADCC_ST_STOPPED)
          next_st.pend = (next_st.state == ADCC_ST_CONVERT);
        next_st.state = ADCC_ST_STOPPED;
      end
      else if (st.state == ADCC_ST_STOPPED)
      begin
        next_st.state    = st.pend ? ADCC_ST_CONVERT : ADCC_ST_IDLE;
        next_st.tick_cnt = 4'h0;
      end

      // channel code drives the analog mux
      next_st.mux_sel     = next_st.chan;
      // power off on all-ones code or in stop
      next_st.power_en    = next_st.state != ADCC_ST_STOPPED
                            && next_st.chan != `ADCC_CHAN_OFF;
      next_st.sample_hold = next_st.state == ADCC_ST_CONVERT
                            && next_st.tick_cnt < `ADCC_SAMPLE_TICKS;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st <= RESET_ST;
    else
      st <= next_st;
  end

  assign rd_data       = st.rd_data;
  assign irq_req       = st.irq;
  assign conv_power_en = st.power_en;
  assign sample_hold   = st.sample_hold;
  assign mux_select    = st.mux_sel;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_end_polled;
    conv_end && !st.irq_en;
  endsequence

  sequence s_end_irq;
    conv_end && st.irq_en;
  endsequence

  sequence s_clear_irq;
    (wr_sc || rd_res) && !conv_end;
  endsequence

  done_masked_a: assert property (
    st.irq_en |-> !st.conv_done)
    else $error("done flag set while interrupt enabled");

  done_sets_a: assert property (
    s_end_polled |=> st.conv_done && !irq_req)
    else $error("done flag not set at conversion end");

  done_read_clear_a: assert property (
    (rd_res && !conv_end) |=> !st.conv_done)
    else $error("result read did not clear done flag");

  irq_raise_a: assert property (
    s_end_irq |=> irq_req ##1 (irq_req || $past(rd_res) || $past(wr_sc) || !$past(ce)))
    else $error("interrupt not raised at conversion end");

  irq_drop_a: assert property (
    s_clear_irq |=> !irq_req)
    else $error("interrupt not dropped by access");

  power_off_a: assert property (
    (wr_sc && wr_data[4:0] == 5'h1f) |=> !conv_power_en && st.state == ADCC_ST_IDLE)
    else $error("power-off code did not stop converter");

  stop_abort_a: assert property (
    (stop_mode && ce) |=> st.state == ADCC_ST_STOPPED && !conv_power_en)
    else $error("stop mode did not abort conversion");

  low_frozen_a: assert property (
    (st.lock && adcc_interlocked(st.mode) && !rd_low && !wr_ck) |=> $stable(st.res_low))
    else $error("low result changed while locked");

  trunc_high_a: assert property (
    (conv_end && st.mode == ADCC_MODE_TRUNC) |=> st.res_high == 8'h00 && !st.lock)
    else $error("truncation mode high register not zero");

  single_idle_a: assert property (
    (conv_end && !st.cont) |=> st.state == ADCC_ST_IDLE)
    else $error("single conversion did not stop");

  read_late_a: assert property (
    (rd_strobe && ce && addr == 2'h0) ##1 (ce && !rd_strobe) |=> rd_data == 8'h00)
    else $error("read data held past its cycle");

endmodule

/* common/adcc_defs.svh */
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// register offsets
`define ADCC_OFF_STATUS   2'h0
`define ADCC_OFF_HIGH     2'h1
`define ADCC_OFF_LOW      2'h2
`define ADCC_OFF_CLOCK    2'h3

// status_control_reg fields
`define ADCC_SC_DONE_BIT  7
`define ADCC_SC_IE_BIT    6
`define ADCC_SC_CONT_BIT  5
`define ADCC_SC_CHAN_MSB  4
`define ADCC_SC_CHAN_LSB  0

// clock_config_reg fields
`define ADCC_CK_PRESC_MSB 7
`define ADCC_CK_PRESC_LSB 5
`define ADCC_CK_MODE_MSB  3
`define ADCC_CK_MODE_LSB  2

// channel codes
`define ADCC_CHAN_REF_HI  5'h1d
`define ADCC_CHAN_REF_LO  5'h1e
`define ADCC_CHAN_OFF     5'h1f

// reset values
`define ADCC_CHAN_RESET   5'h1f
`define ADCC_PRESC_RESET  3'h0
`define ADCC_MODE_RESET   2'h1

// timing in converter clock ticks
`define ADCC_CONV_TICKS   16
`define ADCC_CONV_LAST    4'hf
`define ADCC_SAMPLE_TICKS 4'h4
`endif

/* common/adcc_pkg.sv */
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_ST_IDLE    = 2'b00,
    ADCC_ST_CONVERT = 2'b01,
    ADCC_ST_STOPPED = 2'b10
  } adcc_state_e;

  typedef enum logic [1:0] {
    ADCC_MODE_TRUNC  = 2'b00,
    ADCC_MODE_RIGHT  = 2'b01,
    ADCC_MODE_LEFT   = 2'b10,
    ADCC_MODE_SIGNED = 2'b11
  } adcc_mode_e;

  typedef struct packed {
    logic [3:0] cnt;
  } adcc_presc_s;

  typedef struct packed {
    adcc_state_e state;
    logic [3:0]  tick_cnt;
    logic        pend;
    logic        conv_done;
    logic        irq_en;
    logic        cont;
    logic [4:0]  chan;
    logic [2:0]  presc;
    adcc_mode_e  mode;
    logic [7:0]  res_high;
    logic [7:0]  res_low;
    logic        lock;
    logic        irq;
    logic [9:0]  sync1;
    logic [9:0]  sync2;
    logic [7:0]  rd_data;
    logic        power_en;
    logic        sample_hold;
    logic [4:0]  mux_sel;
  } adcc_top_s;

endpackage

/* logic/adcc_prescaler.sv */
`timescale 1ns/1ns
`include "adcc_defs.svh"
module adcc_prescaler
  import adcc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] code,
  output logic            tick
);

  adcc_presc_s st;
  adcc_presc_s next_st;
  logic [3:0]  last;

  function automatic logic [3:0] adcc_div_last(input logic [2:0] c);
    logic [3:0] r;
    r = 4'hf;
    case (c)
      3'h0:    r = 4'h0;
      3'h1:    r = 4'h1;
      3'h2:    r = 4'h3;
      3'h3:    r = 4'h7;
      default: r = 4'hf;
    endcase
    return r;
  endfunction

  assign last = adcc_div_last(code);
  assign tick = run && ce && (st.cnt == last);

  always_comb
  begin
    next_st = st;
    if (ce)
    begin
      // counter held at zero while idle so each start sees a fresh phase
      if (!run || st.cnt == last)
        next_st.cnt = 4'h0;
      else
        next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sixteen_divide_a: assert property (
    (run && ce && code[2] && st.cnt == 4'h0) |-> !tick)
    else $error("divide by sixteen ticked early");

endmodule

/* logic/adcc_formatter.sv */
`timescale 1ns/1ns
module adcc_formatter
  import adcc_pkg::*;
(
  input  wire logic [9:0] result,
  input  wire adcc_mode_e mode,
  output logic [7:0]      high,
  output logic [7:0]      low
);

  always_comb
  begin
    high = 8'h00;
    low  = 8'h00;
    case (mode)
      ADCC_MODE_TRUNC:
      begin
        high = 8'h00;
        low  = result[9:2];
      end
      ADCC_MODE_RIGHT:
      begin
        high = {6'h00, result[9:8]};
        low  = result[7:0];
      end
      ADCC_MODE_LEFT:
      begin
        high = result[9:2];
        low  = {result[1:0], 6'h00};
      end
      default:
      begin
        high = {~result[9], result[8:2]};
        low  = {result[1:0], 6'h00};
      end
    endcase
  end

endmodule

/* testbench/adcc_top_bench.sv */
`timescale 1ns/1ns
`include "adcc_defs.svh"
module adcc_top_bench
  import adcc_pkg::*;
;
  logic       sys_clk;
  logic       srst;
  logic       ce;
  logic [1:0] addr;
  logic [7:0] wr_data;
  logic       wr_strobe;
  logic       rd_strobe;
  logic [7:0] rd_data;
  logic       stop_mode;
  logic [9:0] sar_result;
  logic       irq_req;
  logic       conv_power_en;
  logic       sample_hold;
  logic [4:0] mux_select;
  int         fails;
  int         checks_done;
  int         cyc;
  int         n;
  logic [7:0] v;
  logic [7:0] h;
  logic [7:0] l;
  logic [9:0] r;
  logic [9:0] r2;
  logic [15:0] e;
  logic [1:0] m;
  logic [4:0] chans [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                             `ADCC_CHAN_REF_HI, `ADCC_CHAN_REF_LO};
  logic [2:0] pcs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int         dv [6] = '{1, 2, 4, 8, 16, 16};

  adcc_top dut (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .ce            (ce),
    .addr          (addr),
    .wr_data       (wr_data),
    .wr_strobe     (wr_strobe),
    .rd_strobe     (rd_strobe),
    .rd_data       (rd_data),
    .stop_mode     (stop_mode),
    .sar_result    (sar_result),
    .irq_req       (irq_req),
    .conv_power_en (conv_power_en),
    .sample_hold   (sample_hold),
    .mux_select    (mux_select)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // expected {high, low} for one result in one justify mode
  function automatic logic [15:0] fmt(input logic [9:0] x, input logic [1:0] md);
    case (md)
      2'h0: fmt = {8'h00, x[9:2]};
      2'h1: fmt = {6'h00, x[9:8], x[7:0]};
      2'h2: fmt = {x[9:2], x[1:0], 6'h00};
      default: fmt = {~x[9], x[8:2], x[1:0], 6'h00};
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
  endtask

  // read data stand one cycle and are taken at its closing edge
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    @(posedge sys_clk);
    d = rd_data;
  endtask

  task automatic wait_done(output logic [7:0] s);
    int k;
    k = 0;
    s = 8'h00;
    while (s[7] !== 1'b1 && k < 100)
    begin
      rd(`ADCC_OFF_STATUS, s);
      k++;
    end
  endtask

  // hang guard, well above the longest expected run
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(35));
    srst = 1'b1;
    ce = 1'b1;
    addr = 2'h0;
    wr_data = 8'h00;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    stop_mode = 1'b0;
    sar_result = 10'h000;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    #1 check(mux_select, `ADCC_CHAN_OFF);
    check({irq_req, conv_power_en}, 2'h0);
    rd(`ADCC_OFF_STATUS, v);
    check(v, 8'h1f);
    rd(`ADCC_OFF_CLOCK, v);
    check(v, 8'h04);
    rd(`ADCC_OFF_HIGH, h);
    rd(`ADCC_OFF_LOW, l);
    check({h, l}, 16'h0000);
    // a strobe with the clock enable low must not land
    @(posedge sys_clk) ce <= 1'b0;
    wr(`ADCC_OFF_CLOCK, 8'hff);
    ce <= 1'b1;
    rd(`ADCC_OFF_CLOCK, v);
    check(v, 8'h04);
    wr(`ADCC_OFF_CLOCK, 8'hff);
    rd(`ADCC_OFF_CLOCK, v);
    check(v, 8'hec);
    wr(`ADCC_OFF_HIGH, 8'hff);
    rd(`ADCC_OFF_HIGH, v);
    check(v, 8'h00);
    // channels 0 to 7 and both reference codes once, cycling all four formats
    for (int i = 0; i < 10; i++)
    begin
      m = 2'(i % 4);
      wr(`ADCC_OFF_CLOCK, {4'h0, m, 2'h0});
      r = 10'($urandom);
      sar_result <= r;
      wr(`ADCC_OFF_STATUS, {3'h0, chans[i]});
      repeat (2) @(posedge sys_clk);
      #1 check(mux_select, chans[i]);
      check({conv_power_en, sample_hold}, 2'h3);
      wait_done(v);
      check(v, {3'h4, chans[i]});
      rd(`ADCC_OFF_HIGH, h);
      rd(`ADCC_OFF_LOW, l);
      check({h, l}, fmt(r, m));
      rd(`ADCC_OFF_STATUS, v);
      check(v, {3'h0, chans[i]});
    end
    // high read freezes low while later results are dropped
    wr(`ADCC_OFF_CLOCK, 8'h04);
    r = 10'($urandom);
    sar_result <= r;
    wr(`ADCC_OFF_STATUS, 8'h20);
    repeat (40) @(posedge sys_clk);
    e = fmt(r, 2'h1);
    rd(`ADCC_OFF_HIGH, h);
    check(h, e[15:8]);
    r2 = r ^ 10'h3ff;
    sar_result <= r2;
    repeat (60) @(posedge sys_clk);
    rd(`ADCC_OFF_LOW, l);
    check(l, e[7:0]);
    repeat (40) @(posedge sys_clk);
    rd(`ADCC_OFF_HIGH, h);
    rd(`ADCC_OFF_LOW, l);
    check({h, l}, fmt(r2, 2'h1));
    // truncation keeps updating low with high idle
    wr(`ADCC_OFF_CLOCK, 8'h00);
    repeat (40) @(posedge sys_clk);
    rd(`ADCC_OFF_HIGH, h);
    r = 10'($urandom);
    sar_result <= r;
    repeat (40) @(posedge sys_clk);
    rd(`ADCC_OFF_LOW, l);
    check({h, l}, {8'h00, r[9:2]});
    // stop aborts a fresh conversion, exit restarts it
    wr(`ADCC_OFF_STATUS, 8'h20);
    rd(`ADCC_OFF_LOW, l);
    stop_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check({conv_power_en, sample_hold}, 2'h0);
    repeat (40) @(posedge sys_clk);
    rd(`ADCC_OFF_STATUS, v);
    check(v, 8'h20);
    stop_mode <= 1'b0;
    repeat (40) @(posedge sys_clk);
    #1 check(conv_power_en, 1'b1);
    rd(`ADCC_OFF_STATUS, v);
    check(v, 8'ha0);
    // all-ones channel code powers down
    wr(`ADCC_OFF_STATUS, 8'h1f);
    rd(`ADCC_OFF_LOW, l);
    repeat (40) @(posedge sys_clk);
    #1 check(conv_power_en, 1'b0);
    rd(`ADCC_OFF_STATUS, v);
    check(v, 8'h1f);
    // results after power-on only timed
    // interrupt timing per divider, cleared by read or by write
    for (int j = 0; j < 6; j++)
    begin
      wr(`ADCC_OFF_CLOCK, {pcs[j], 5'h04});
      wr(`ADCC_OFF_STATUS, 8'h45);
      n = 0;
      while (irq_req !== 1'b1 && n < 600)
      begin
        @(posedge sys_clk);
        n++;
      end
      check(n >= 16 * dv[j] - 1 && n <= 17 * dv[j] + 2, 1'b1);
      rd(`ADCC_OFF_STATUS, v);
      check(v, 8'h45);
      if (j % 2 == 0)
        rd(`ADCC_OFF_LOW, l);
      else
        wr(`ADCC_OFF_STATUS, 8'h45);
      #1 check(irq_req, 1'b0);
    end
    wr(`ADCC_OFF_STATUS, 8'h1f);
    finish_test();
  end
endmodule
